// ---- logic/serial_port_interrupt_status.sv ----
// Behaviour
// (R01) raw status read returns all four source states before masking
// (R02) writes to raw status are ignored; raw flags unchanged
// (R03) masked status read returns each source ANDed with its mask bit
// (R04) writes to masked status are ignored; no flag or mask changes
// (R05) masked bit 1 reads one when time-out flagged and unmasked
// (R06) masked bit 0 reads one when overrun flagged and unmasked
// (R07) mask bits reset to zero; one passes the raw flag, zero blocks
// (R08) writing one to a clear bit resets time-out/overrun; zero has no effect
// (R09) tx flag bit 3 set at half full or less, resets one; rx bit 2
`timescale 1ns/1ps
`default_nettype none

`include "spis_consts.svh"

module serial_port_interrupt_status
	import spis_pkg::*;
(
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite write address
	input  wire logic        awvalid,
	output var  logic        awready,
	input  wire logic [11:0] awaddr,
	input  wire logic [2:0]  awprot,
	// axi4-lite write data
	input  wire logic        wvalid,
	output var  logic        wready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	// axi4-lite write response
	output var  logic        bvalid,
	input  wire logic        bready,
	output var  logic [1:0]  bresp,
	// axi4-lite read address
	input  wire logic        arvalid,
	output var  logic        arready,
	input  wire logic [11:0] araddr,
	input  wire logic [2:0]  arprot,
	// axi4-lite read data
	output var  logic        rvalid,
	input  wire logic        rready,
	output var  logic [31:0] rdata,
	output var  logic [1:0]  rresp,
	// interrupt sources
	input  wire logic        tx_fifo_half_or_less,
	input  wire logic        rx_fifo_half_or_more,
	input  wire logic        rx_timeout_event,
	input  wire logic        rx_overrun_event,
	// interrupt
	output var  logic        irq
);

	// ****************************************************************
	// state
	// ****************************************************************
	ctl_state_s       st_q;
	ctl_state_s       st_d;
	logic [1:0]       line_set;
	logic [1:0]       line_clr;
	logic [1:0]       line_q;
	irq_src_s         raw;
	irq_src_s         masked;
	irq_src_s         evt_set;
	irq_src_s         evt_clr;
	logic [3:0]       evt_q;
	logic             do_write;
	logic             rd_take;
	logic             unused_prot;

	assign unused_prot = ^{awprot, arprot};

	// ****************************************************************
	// source views
	// ****************************************************************
	assign raw.tx_level   = st_q.tx_level; // R09
	assign raw.rx_level   = st_q.rx_level; // R09
	assign raw.rx_timeout = line_q[`BIT_RX_TIMEOUT];
	assign raw.rx_overrun = line_q[`BIT_RX_OVERRUN];
	assign masked         = raw & st_q.mask; // R03 R05 R06 R07

	// ****************************************************************
	// time-out and overrun flags
	// ****************************************************************
	assign do_write = st_q.aw_have && st_q.w_have && !st_q.bvalid;
	assign rd_take  = arvalid && st_q.arready;

	assign line_set[`BIT_RX_TIMEOUT] = rx_timeout_event;
	assign line_set[`BIT_RX_OVERRUN] = rx_overrun_event;

	// write one clears, zero leaves alone
	assign line_clr = (do_write && st_q.aw_addr == `OFF_CLEAR
		&& st_q.w_strb[0]) ? st_q.w_data[1:0] : 2'h0; // R08

	sticky_flags #(
		.WIDTH     (2),
		.RESET_VAL (2'h0)
	) u_line_flags (
		.aclk    (aclk),
		.aresetn (aresetn),
		.set     (line_set),
		.clr     (line_clr),
		.flags_q (line_q)
	);

	// ****************************************************************
	// event status, cleared by reading it
	// ****************************************************************
	assign evt_set = raw & ~st_q.prev_raw;
	assign evt_clr = (rd_take && araddr == `OFF_EVT_STATUS) ? 4'hF : 4'h0;

	sticky_flags #(
		.WIDTH     (`SRC_W),
		.RESET_VAL (4'h0)
	) u_evt_flags (
		.aclk    (aclk),
		.aresetn (aresetn),
		.set     (evt_set),
		.clr     (evt_clr),
		.flags_q (evt_q)
	);

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		st_d          = st_q;
		st_d.tx_level = tx_fifo_half_or_less; // R09
		st_d.rx_level = rx_fifo_half_or_more; // R09
		st_d.prev_raw = raw;
		st_d.irq      = |(evt_q & st_q.evt_mask);

		// write address and data, taken in either order
		if (awvalid && st_q.awready) begin
			st_d.aw_have = 1'b1;
			st_d.aw_addr = awaddr;
		end
		if (wvalid && st_q.wready) begin
			st_d.w_have = 1'b1;
			st_d.w_data = wdata;
			st_d.w_strb = wstrb;
		end
		if (st_q.bvalid && bready) begin
			st_d.bvalid = 1'b0;
		end

		if (do_write) begin
			st_d.aw_have = 1'b0;
			st_d.w_have  = 1'b0;
			st_d.bvalid  = 1'b1;
			st_d.bresp   = `RESP_OKAY;
			case (st_q.aw_addr)
				`OFF_MASK: begin
					if (st_q.w_strb[0]) begin
						st_d.mask = st_q.w_data[3:0]; // R07
					end
				end
				`OFF_RAW: begin
					st_d.bresp = `RESP_OKAY; // R02
				end
				`OFF_MASKED: begin
					st_d.bresp = `RESP_OKAY; // R04
				end
				`OFF_CLEAR: begin
					st_d.bresp = `RESP_OKAY;
				end
				`OFF_EVT_STATUS: begin
					st_d.bresp = `RESP_OKAY;
				end
				`OFF_EVT_MASK: begin
					if (st_q.w_strb[0]) begin
						st_d.evt_mask = st_q.w_data[3:0];
					end
				end
				default: begin
					st_d.bresp = `RESP_SLVERR;
				end
			endcase
		end
		st_d.awready = !st_d.aw_have && !st_d.bvalid;
		st_d.wready  = !st_d.w_have && !st_d.bvalid;

		// read channel
		if (st_q.rvalid && rready) begin
			st_d.rvalid = 1'b0;
		end
		if (rd_take) begin
			st_d.rvalid = 1'b1;
			st_d.rresp  = `RESP_OKAY;
			st_d.rdata  = 32'h0;
			case (araddr)
				`OFF_MASK: begin
					st_d.rdata[3:0] = st_q.mask; // R07
				end
				`OFF_RAW: begin
					st_d.rdata[3:0] = raw; // R01
				end
				`OFF_MASKED: begin
					st_d.rdata[3:0] = masked; // R03
				end
				`OFF_CLEAR: begin
					st_d.rdata = 32'h0;
				end
				`OFF_EVT_STATUS: begin
					st_d.rdata[3:0] = evt_q;
				end
				`OFF_EVT_MASK: begin
					st_d.rdata[3:0] = st_q.evt_mask;
				end
				default: begin
					st_d.rresp = `RESP_SLVERR;
				end
			endcase
		end
		st_d.arready = !st_d.rvalid;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q          <= '0;
			st_q.tx_level <= 1'b1; // R09
			st_q.prev_raw <= `RESET_RAW;
			st_q.mask     <= `RESET_MASK; // R07
			st_q.evt_mask <= `RESET_EVT_MASK;
		end else begin
			st_q <= st_d;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign awready = st_q.awready;
	assign wready  = st_q.wready;
	assign bvalid  = st_q.bvalid;
	assign bresp   = st_q.bresp;
	assign arready = st_q.arready;
	assign rvalid  = st_q.rvalid;
	assign rdata   = st_q.rdata;
	assign rresp   = st_q.rresp;
	assign irq     = st_q.irq;

	// ****************************************************************
	// checks
	// ****************************************************************
	property p_raw_read;
		@(posedge aclk) disable iff (!aresetn)
		(rd_take && araddr == `OFF_RAW)
			|=> (rvalid && rdata == {28'h0, $past(raw)});
	endproperty
	a_raw_read: assert property (p_raw_read) // R01
		else $error("raw status read wrong");

	property p_raw_write;
		@(posedge aclk) disable iff (!aresetn)
		(do_write && st_q.aw_addr == `OFF_RAW && !rx_timeout_event
			&& !rx_overrun_event)
			|=> ($stable(line_q) && $stable(st_q.mask)
			&& bresp == `RESP_OKAY);
	endproperty
	a_raw_write: assert property (p_raw_write) // R02
		else $error("raw status write changed state");

	property p_masked_read;
		@(posedge aclk) disable iff (!aresetn)
		(rd_take && araddr == `OFF_MASKED)
			|=> (rdata[3:0] == ($past(raw) & $past(st_q.mask))
			&& rdata[31:4] == 28'h0);
	endproperty
	a_masked_read: assert property (p_masked_read) // R03
		else $error("masked status read wrong");

	property p_masked_write;
		@(posedge aclk) disable iff (!aresetn)
		(do_write && st_q.aw_addr == `OFF_MASKED && !rx_timeout_event
			&& !rx_overrun_event)
			|=> ($stable(st_q.mask) && $stable(line_q)
			&& $stable(st_q.evt_mask));
	endproperty
	a_masked_write: assert property (p_masked_write) // R04
		else $error("masked status write changed state");

	property p_timeout_masked;
		@(posedge aclk) disable iff (!aresetn)
		(rd_take && araddr == `OFF_MASKED)
			|=> (rdata[`BIT_RX_TIMEOUT] == ($past(line_q[`BIT_RX_TIMEOUT])
			&& $past(st_q.mask.rx_timeout)));
	endproperty
	a_timeout_masked: assert property (p_timeout_masked) // R05
		else $error("masked time-out bit wrong");

	property p_overrun_masked;
		@(posedge aclk) disable iff (!aresetn)
		(rd_take && araddr == `OFF_MASKED
			&& line_q[`BIT_RX_OVERRUN] && st_q.mask.rx_overrun)
			|=> rdata[`BIT_RX_OVERRUN];
	endproperty
	a_overrun_masked: assert property (p_overrun_masked) // R06
		else $error("masked overrun bit not seen");

	property p_mask_write;
		@(posedge aclk) disable iff (!aresetn)
		(do_write && st_q.aw_addr == `OFF_MASK && st_q.w_strb[0])
			|=> (st_q.mask == $past(st_q.w_data[3:0]) && bvalid);
	endproperty
	a_mask_write: assert property (p_mask_write) // R07
		else $error("mask write not stored");

	property p_clear_one;
		@(posedge aclk) disable iff (!aresetn)
		(do_write && st_q.aw_addr == `OFF_CLEAR && st_q.w_strb[0]
			&& st_q.w_data[`BIT_RX_TIMEOUT] && !rx_timeout_event)
			|=> !line_q[`BIT_RX_TIMEOUT];
	endproperty
	a_clear_one: assert property (p_clear_one) // R08
		else $error("time-out flag not cleared");

	property p_clear_zero;
		@(posedge aclk) disable iff (!aresetn)
		(do_write && st_q.aw_addr == `OFF_CLEAR
			&& !st_q.w_data[`BIT_RX_OVERRUN] && line_q[`BIT_RX_OVERRUN])
			|=> line_q[`BIT_RX_OVERRUN];
	endproperty
	a_clear_zero: assert property (p_clear_zero) // R08
		else $error("overrun flag cleared by zero");

	property p_level_flags;
		@(posedge aclk) disable iff (!aresetn)
		1'b1 |=> (raw.tx_level == $past(tx_fifo_half_or_less)
			&& raw.rx_level == $past(rx_fifo_half_or_more));
	endproperty
	a_level_flags: assert property (p_level_flags) // R09
		else $error("level flag does not follow its source");

	property p_irq_level;
		@(posedge aclk) disable iff (!aresetn)
		((evt_q & st_q.evt_mask) != 4'h0) |=> irq;
	endproperty
	a_irq_level: assert property (p_irq_level)
		else $error("interrupt missing for unmasked event");

	property p_write_answer;
		@(posedge aclk) disable iff (!aresetn)
		do_write |=> (bvalid && !awready && !wready);
	endproperty
	a_write_answer: assert property (p_write_answer)
		else $error("write response late");

endmodule : serial_port_interrupt_status

`default_nettype wire

// ---- logic/spis_consts.svh ----
`ifndef SPIS_CONSTS_SVH
`define SPIS_CONSTS_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define OFF_MASK        12'h014
`define OFF_RAW         12'h018
`define OFF_MASKED      12'h01C
`define OFF_CLEAR       12'h020
`define OFF_EVT_STATUS  12'h024
`define OFF_EVT_MASK    12'h028

// ****************************************************************
// field positions, shared by all four-bit source registers
// ****************************************************************
`define BIT_TX_LEVEL    3
`define BIT_RX_LEVEL    2
`define BIT_RX_TIMEOUT  1
`define BIT_RX_OVERRUN  0
`define SRC_W           4

// ****************************************************************
// reset values
// ****************************************************************
`define RESET_MASK      4'h0
`define RESET_RAW       4'h8
`define RESET_EVT_MASK  4'h0

// ****************************************************************
// bus answers
// ****************************************************************
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// ---- logic/spis_pkg.sv ----
package spis_pkg;

	// bit 3 down to bit 0, same layout in every source register
	typedef struct packed {
		logic tx_level;
		logic rx_level;
		logic rx_timeout;
		logic rx_overrun;
	} irq_src_s;

	typedef struct packed {
		logic        aw_have;
		logic [11:0] aw_addr;
		logic        w_have;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		irq_src_s    mask;
		irq_src_s    evt_mask;
		irq_src_s    prev_raw;
		logic        tx_level;
		logic        rx_level;
		logic        irq;
	} ctl_state_s;

endpackage : spis_pkg

// ---- logic/sticky_flags.sv ----
`timescale 1ns/1ps
`default_nettype none

module sticky_flags #(
	parameter int unsigned          WIDTH     = 4,
	parameter logic [WIDTH-1:0]     RESET_VAL = '0
) (
	// clock and reset
	input  wire logic             aclk,
	input  wire logic             aresetn,
	// set and clear strobes
	input  wire logic [WIDTH-1:0] set,
	input  wire logic [WIDTH-1:0] clr,
	// flags
	output var  logic [WIDTH-1:0] flags_q
);

	logic [WIDTH-1:0] flags_d;

	// set beats a clear in the same cycle
	always_comb begin
		flags_d = (flags_q & ~clr) | set;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flags_q <= RESET_VAL;
		end else begin
			flags_q <= flags_d;
		end
	end

	property p_set_wins;
		@(posedge aclk) disable iff (!aresetn)
		(set != '0) |=> ((flags_q & $past(set)) == $past(set));
	endproperty
	a_set_wins: assert property (p_set_wins)
		else $error("sticky flag lost its set");

	property p_no_clear_keeps;
		@(posedge aclk) disable iff (!aresetn)
		1'b1 |=> ((~flags_q & $past(flags_q) & ~$past(clr)) == '0);
	endproperty
	a_no_clear_keeps: assert property (p_no_clear_keeps) // R08
		else $error("sticky flag fell without a clear");

endmodule : sticky_flags

`default_nettype wire

// ---- verif/serial_port_interrupt_status_tb.sv ----
`timescale 1ns/1ps
`default_nettype none

`include "spis_consts.svh"

module serial_port_interrupt_status_tb;
	import spis_pkg::*;

	logic        aclk, aresetn;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, irq;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic        tx_lvl, rx_lvl, to_evt, ov_evt;
	int          n_errors, checked;

	serial_port_interrupt_status i_serial_port_interrupt_status (
		.aclk(aclk), .aresetn(aresetn),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
		.wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
		.bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
		.tx_fifo_half_or_less(tx_lvl), .rx_fifo_half_or_more(rx_lvl),
		.rx_timeout_event(to_evt), .rx_overrun_event(ov_evt), .irq(irq)
	);

	always #2 aclk = ~aclk;

	// ****************************************************************
	// helpers
	// ****************************************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic report_and_stop;
		$display("errors %0d, comparisons %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : report_and_stop

	task automatic cycles(input int n);
		repeat (n) @(posedge aclk);
	endtask : cycles

	task automatic wr(input logic [11:0] a, input logic [31:0] d,
			input logic [1:0] exp_resp);
		logic aw_ok, w_ok, b_ok;
		int   n;
		aw_ok = 1'b0;
		w_ok  = 1'b0;
		b_ok  = 1'b0;
		n     = 0;
		@(posedge aclk);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		while (!b_ok && n < 200) begin
			@(posedge aclk);
			n++;
			if (!aw_ok && awready) begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_ok && wready) begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
			if (aw_ok && w_ok && bvalid) begin
				b_ok = 1'b1;
				bready <= 1'b0;
				check({30'h0, bresp}, {30'h0, exp_resp});
			end
		end
		if (!b_ok)
			check(32'h0, 32'h1);
	endtask : wr

	task automatic rd(input logic [11:0] a, output logic [31:0] d,
			output logic [1:0] r);
		logic a_ok, r_ok;
		int   n;
		a_ok = 1'b0;
		r_ok = 1'b0;
		n    = 0;
		d    = 32'hFFFFFFFF;
		r    = 2'h3;
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		while (!r_ok && n < 200) begin
			@(posedge aclk);
			n++;
			if (!a_ok && arready) begin
				a_ok = 1'b1;
				arvalid <= 1'b0;
			end
			if (a_ok && rvalid) begin
				r_ok = 1'b1;
				d = rdata;
				r = rresp;
				rready <= 1'b0;
			end
		end
		if (!r_ok)
			check(32'h0, 32'h1);
	endtask : rd

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		check({30'h0, r}, {30'h0, `RESP_OKAY});
		check(d, exp);
	endtask : rd_chk

	task automatic drive_src(input logic tx, input logic rx,
			input logic to, input logic ov);
		@(posedge aclk);
		tx_lvl <= tx;
		rx_lvl <= rx;
		to_evt <= to;
		ov_evt <= ov;
		@(posedge aclk);
		to_evt <= 1'b0;
		ov_evt <= 1'b0;
		cycles(3);
	endtask : drive_src

	// ****************************************************************
	// scenarios
	// ****************************************************************
	task automatic t_reset_values;
		rd_chk(`OFF_RAW, 32'h8);
		rd_chk(`OFF_MASK, 32'h0);
		rd_chk(`OFF_MASKED, 32'h0);
	endtask : t_reset_values

	task automatic t_levels;
		drive_src(1'b0, 1'b1, 1'b0, 1'b0);
		rd_chk(`OFF_RAW, 32'h4);
		wr(`OFF_RAW, 32'h0000000B, `RESP_OKAY);
		rd_chk(`OFF_RAW, 32'h4);
		drive_src(1'b1, 1'b0, 1'b0, 1'b0);
		rd_chk(`OFF_RAW, 32'h8);
	endtask : t_levels

	task automatic t_mask;
		drive_src(1'b1, 1'b1, 1'b1, 1'b1);
		rd_chk(`OFF_RAW, 32'hF);
		rd_chk(`OFF_MASKED, 32'h0);
		wr(`OFF_MASK, 32'h2, `RESP_OKAY);
		rd_chk(`OFF_MASKED, 32'h2);
		wr(`OFF_MASK, 32'h1, `RESP_OKAY);
		rd_chk(`OFF_MASKED, 32'h1);
		wr(`OFF_MASK, 32'hC, `RESP_OKAY);
		rd_chk(`OFF_MASKED, 32'hC);
		wr(`OFF_MASK, 32'hF, `RESP_OKAY);
		wr(`OFF_MASKED, 32'h0, `RESP_OKAY);
		rd_chk(`OFF_MASK, 32'hF);
		rd_chk(`OFF_MASKED, 32'hF);
		drive_src(1'b1, 1'b0, 1'b0, 1'b0);
		rd_chk(`OFF_MASKED, 32'hB);
		wr(`OFF_MASK, 32'h0, `RESP_OKAY);
		rd_chk(`OFF_MASKED, 32'h0);
	endtask : t_mask

	task automatic t_clear;
		// byte 0 strobe low: the clear must not act
		@(posedge aclk);
		wstrb <= 4'hE;
		wr(`OFF_CLEAR, 32'h3, `RESP_OKAY);
		wstrb <= 4'hF;
		rd_chk(`OFF_RAW, 32'hB);
		wr(`OFF_CLEAR, 32'h0, `RESP_OKAY);
		rd_chk(`OFF_RAW, 32'hB);
		wr(`OFF_CLEAR, 32'h2, `RESP_OKAY);
		rd_chk(`OFF_RAW, 32'h9);
		wr(`OFF_CLEAR, 32'h1, `RESP_OKAY);
		rd_chk(`OFF_RAW, 32'h8);
	endtask : t_clear

	task automatic t_irq;
		logic [31:0] d;
		logic [1:0]  r;
		wr(`OFF_EVT_MASK, 32'h2, `RESP_OKAY);
		rd(`OFF_EVT_STATUS, d, r);
		drive_src(1'b1, 1'b0, 1'b1, 1'b0);
		check({31'h0, irq}, 32'h1);
		rd_chk(`OFF_EVT_STATUS, 32'h2);
		cycles(3);
		check({31'h0, irq}, 32'h0);
		wr(`OFF_CLEAR, 32'h2, `RESP_OKAY);
		wr(`OFF_EVT_MASK, 32'h1, `RESP_OKAY);
		drive_src(1'b1, 1'b0, 1'b1, 1'b0);
		check({31'h0, irq}, 32'h0);
		rd_chk(`OFF_EVT_STATUS, 32'h2);
		rd_chk(`OFF_EVT_STATUS, 32'h0);
	endtask : t_irq

	task automatic t_unmapped;
		logic [31:0] d;
		logic [1:0]  r;
		wr(12'h100, 32'hF, `RESP_SLVERR);
		rd(12'h100, d, r);
		check({30'h0, r}, {30'h0, `RESP_SLVERR});
		check(d, 32'h0);
		rd_chk(`OFF_RAW, 32'hA);
	endtask : t_unmapped

	// ****************************************************************
	// main sequence and watchdog
	// ****************************************************************
	initial begin
		aclk     = 1'b0;
		aresetn  = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h0;
		awaddr   = 12'h0;
		araddr   = 12'h0;
		wdata    = 32'h0;
		wstrb    = 4'hF;
		{tx_lvl, rx_lvl, to_evt, ov_evt} = 4'h8;
		n_errors = 0;
		checked  = 0;
		cycles(16);
		aresetn <= 1'b1;
		cycles(2);
		t_reset_values();
		t_levels();
		t_mask();
		t_clear();
		t_irq();
		t_unmapped();
		report_and_stop();
	end

	initial begin
		#100000;
		n_errors++;
		report_and_stop();
	end

endmodule : serial_port_interrupt_status_tb

`default_nettype wire
